/* File: acs_crc8.sv */
module acs_crc8 (
  // Checksum request
  acs_crc_if.calc c
);

  // ==========================================================================
  // Message shaping
  logic [31:0] msg;
  logic [7:0]  stage [0:32];

  // Top byte of the message inverted; narrow words get leading zeros,
  // which leave a zero-seeded remainder unchanged
  always_comb
  begin
    if (c.wide)
      msg = {~c.data[31:31-acs_pkg::CRC_INV_BITS+1], c.data[23:0]};
    else
      msg = {16'h0000, ~c.data[15:8], c.data[7:0]};
  end

  // ==========================================================================
  // Bit-serial division, MSB first; equals appending eight zeros and dividing
  assign stage[0] = 8'h00;

  for (genvar i = 0; i < 32; i++)
  begin : g_div
    logic fb;
    assign fb = stage[i][7] ^ msg[31-i];
    assign stage[i+1] = {stage[i][6:0], 1'b0} ^ (fb ? acs_pkg::CRC_POLY[7:0] : 8'h00);
  end

  assign c.crc = stage[32];

endmodule

/* File: acs_crc_if.sv */
interface acs_crc_if;
  logic [31:0] data;
  logic        wide;
  logic [7:0]  crc;

  // Checksum engine side
  modport calc (
    input  data,
    input  wide,
    output crc
  );

  // Side that asks for a checksum
  modport user (
    output data,
    output wide,
    input  crc
  );
endinterface

/* File: acs_host_model.sv */
module acs_host_model (
  // Frame start reference
  input  wire logic clock,
  // Serial link
  output logic      sclk,
  output logic      csN,
  output logic      serialIn,
  input  wire logic primarySerialOutput,
  input  wire logic secondaryOutputOrFlagPin
);
  timeunit 1ns;
  timeprecision 100ps;

  // Link rests deselected with its clock stopped
  initial
  begin
    sclk = 1'b0;
    csN = 1'b1;
    serialIn = 1'b0;
  end

  // ====================
  // One frame: word MSB first, then the checksum byte
  task automatic frame(input logic [23:0] tx, input int n, output logic [43:0] p, output logic [43:0] s);
    int i;
    p = '0;
    s = '0;
    @(posedge clock);
    csN <= 1'b0;
    #5;
    // Caller asks 16 clocks or more
    for (i = 0; i < n; i++)
    begin
      serialIn = (i < 24) ? tx[23 - i] : 1'b0;
      #3 sclk = 1'b1;
      #3 sclk = 1'b0;
      p[43 - i] = primarySerialOutput;
      s[43 - i] = secondaryOutputOrFlagPin;
    end
    csN = 1'b1;
    serialIn = ~serialIn; // Stale level is not left on the line
    // Long gap so the word crosses before the next frame
    repeat (12) @(posedge clock);
  endtask
endmodule

/* File: acs_pkg.sv */
package acs_pkg;

  // ==========================================================================
  // Frame geometry
  localparam int FRAME_BITS     = 16;
  localparam int CRC_BITS       = 8;
  localparam int CRC_FRAME_BITS = FRAME_BITS + CRC_BITS;
  localparam int DATA_BITS      = 12;
  localparam int RES_BITS       = 18;
  localparam int TX_BITS        = 44;
  localparam int SYNC_DEPTH     = 3;

  // Link bit counter: edge index of the last word bit and last checksum bit
  localparam logic [4:0] CNT_WORD_LAST = 5'(FRAME_BITS - 1);
  localparam logic [4:0] CNT_CRC_LAST  = 5'(CRC_FRAME_BITS - 1);
  localparam logic [4:0] CNT_MAX       = 5'h1f;

  // ==========================================================================
  // Checksum
  localparam logic [8:0] CRC_POLY     = 9'h107;
  localparam int         CRC_INV_BITS = 8;

  // ==========================================================================
  // Command word fields
  localparam int POS_WR   = 15;
  localparam int POS_ADDR = 12;

  // Register addresses
  localparam logic [2:0] ADDR_PRIMARY = 3'h1;
  localparam logic [2:0] ADDR_OUTCTL  = 3'h2;
  localparam logic [2:0] ADDR_FLAGS   = 3'h3;
  localparam logic [2:0] ADDR_LOWLIM  = 3'h4;
  localparam logic [2:0] ADDR_HIGHLIM = 3'h5;

  // Field positions inside the 12-bit data part
  localparam int POS_OS_MODE = 9;
  localparam int POS_CRC_W   = 5;
  localparam int POS_CRC_R   = 4;
  localparam int POS_RES     = 2;
  localparam int POS_SDO     = 8;
  localparam int POS_WFAIL   = 9;
  localparam int POS_SETUP   = 8;
  localparam int POS_B_HIGH  = 5;
  localparam int POS_B_LOW   = 4;
  localparam int POS_A_HIGH  = 1;
  localparam int POS_A_LOW   = 0;

  // Values after reset
  localparam logic [11:0] RST_PRIMARY = 12'h000;
  localparam logic [11:0] RST_OUTCTL  = 12'h000;
  localparam logic [11:0] RST_LOWLIM  = 12'h000;
  localparam logic [11:0] RST_HIGHLIM = 12'hfff;

  // ==========================================================================
  // Types
  typedef enum logic [0:0] {
    WR_IDLE     = 1'b0,
    WR_WAIT_CRC = 1'b1
  } acs_wr_state_t;

  typedef struct packed {
    logic [2:0]    wordSync;
    logic [2:0]    crcSync;
    logic [11:0]   primarySetup;
    logic [11:0]   outputCtl;
    logic [11:0]   lowLimit;
    logic [11:0]   highLimit;
    logic          writeFail;
    acs_wr_state_t wrState;
    logic [15:0]   pendWord;
    logic [43:0]   txPrim;
    logic [17:0]   txSec;
    logic          txSecOn;
  } acs_sys_t;

  typedef struct packed {
    logic [4:0]  bitCnt;
    logic [15:0] rxShift;
    logic [43:0] txPrim;
    logic [17:0] txSec;
    logic        primOut;
    logic        primEn;
    logic        secOut;
    logic        secEn;
  } acs_frame_t;

  typedef struct packed {
    logic [15:0] frameWord;
    logic [7:0]  crcByte;
    logic        wordTgl;
    logic        crcTgl;
  } acs_hold_t;

endpackage

/* File: acs_spi_regs.sv */
module acs_spi_regs (
  // System clock and reset
  input  wire logic        clock,
  input  wire logic        nrst,
  // Serial link pins
  input  wire logic        sclk,
  input  wire logic        csN,
  input  wire logic        serialIn,
  output logic             primarySerialOutput,
  output logic             primarySerialOutputEn,
  output logic             secondaryOutputOrFlagPin,
  output logic             secondaryOutputOrFlagPinEn,
  // Converter side
  input  wire logic [17:0] chanAResult,
  input  wire logic [17:0] chanBResult,
  input  wire logic        setupFail,
  input  wire logic [3:0]  limitFlags,
  // Configuration and status out
  output logic [11:0]      primarySetup,
  output logic [11:0]      outputCtl,
  output logic [11:0]      lowLimit,
  output logic [11:0]      highLimit,
  output logic             writeCheckFailureFlag
);

  // ==========================================================================
  // State
  acs_pkg::acs_sys_t   sys_q;
  acs_pkg::acs_sys_t   sys_d;
  acs_pkg::acs_frame_t frm_q;
  acs_pkg::acs_frame_t frm_d;
  acs_pkg::acs_hold_t  hld_q;
  acs_pkg::acs_hold_t  hld_d;

  // Link reset and crossing events
  logic        linkRstN;
  logic        wordEvt;
  logic        crcEvt;

  // Decoded command
  logic        isWrite;
  logic [2:0]  regSel;
  logic [11:0] payload;
  logic        readOk;
  logic        needCrc;

  // Outgoing data and mode bits
  logic [15:0] regWord;
  logic [15:0] resA;
  logic [15:0] resB;
  logic [7:0]  txCrc;
  logic        oneWire;
  logic        boost;
  logic        crcRdOn;

  // Failure flag set and clear, worked out per clock
  logic        setFail;
  logic        clrFail;

  // Two carriers, so the outgoing and incoming checks never share inputs
  acs_crc_if txCrcIf ();
  acs_crc_if rxCrcIf ();

  // ==========================================================================
  // Checksum engines: one for outgoing data, one for incoming writes
  acs_crc8 u_tx_crc (
    .c (txCrcIf)
  );

  acs_crc8 u_rx_crc (
    .c (rxCrcIf)
  );

  // ==========================================================================
  // Link domain
  // Frame logic is cleared while chip select is high; the clock may stop
  // between frames, so nothing here waits for an edge outside a frame
  assign linkRstN = nrst & ~csN;

  // Bit counting, shifting in and out
  always_comb
  begin
    frm_d = frm_q;
    // Every edge shifts in; the counter saturates so long frames never wrap
    if (frm_q.bitCnt != acs_pkg::CNT_MAX)
      frm_d.bitCnt = frm_q.bitCnt + 5'd1;
    frm_d.rxShift = {frm_q.rxShift[14:0], serialIn};
    if (frm_q.bitCnt == 5'd0)
    begin
      // Image is stable here: the system side only changes it after
      // the previous frame word has crossed over
      frm_d.primOut = sys_q.txPrim[acs_pkg::TX_BITS-1];
      frm_d.txPrim  = {sys_q.txPrim[acs_pkg::TX_BITS-2:0], 1'b0};
      frm_d.secOut  = sys_q.txSec[acs_pkg::RES_BITS-1];
      frm_d.txSec   = {sys_q.txSec[acs_pkg::RES_BITS-2:0], 1'b0};
      frm_d.primEn  = 1'b1;
      frm_d.secEn   = sys_q.txSecOn;
    end
    else
    begin
      // Checksum bits leave right behind the data bits, MSB first
      frm_d.primOut = frm_q.txPrim[acs_pkg::TX_BITS-1];
      frm_d.txPrim  = {frm_q.txPrim[acs_pkg::TX_BITS-2:0], 1'b0};
      frm_d.secOut  = frm_q.txSec[acs_pkg::RES_BITS-1];
      frm_d.txSec   = {frm_q.txSec[acs_pkg::RES_BITS-2:0], 1'b0};
    end
  end

  // Serial clock flops; chip select high clears them at once
  always_ff @(posedge sclk or negedge linkRstN)
  begin
    if (!linkRstN)
      frm_q <= '0;
    else
      frm_q <= frm_d;
  end

  // Captured words survive chip select; toggles mark each capture
  always_comb
  begin
    hld_d = hld_q;
    if (frm_q.bitCnt == acs_pkg::CNT_WORD_LAST)
    begin
      hld_d.frameWord = {frm_q.rxShift[14:0], serialIn};
      hld_d.wordTgl   = ~hld_q.wordTgl;
    end
    if (frm_q.bitCnt == acs_pkg::CNT_CRC_LAST)
    begin
      hld_d.crcByte = {frm_q.rxShift[6:0], serialIn};
      hld_d.crcTgl  = ~hld_q.crcTgl;
    end
  end

  // Only system reset clears these, so a word survives the end of its frame.
  // Limitation: a new frame inside the crossing time overwrites a held word
  always_ff @(posedge sclk or negedge nrst)
  begin
    if (!nrst)
      hld_q <= '0;
    else
      hld_q <= hld_d;
  end

  // ==========================================================================
  // Command decode
  // Frame word is read only after its toggle has passed the synchroniser
  assign isWrite = hld_q.frameWord[acs_pkg::POS_WR];
  assign regSel  = hld_q.frameWord[acs_pkg::POS_ADDR +: 3];
  assign payload = hld_q.frameWord[acs_pkg::DATA_BITS-1:0];

  // A toggle counts once stages two and three disagree; toggles cost a
  // few clocks of latency but need no handshake back to the link side
  assign wordEvt = sys_q.wordSync[2] ^ sys_q.wordSync[1];
  assign crcEvt  = sys_q.crcSync[2] ^ sys_q.crcSync[1];

  // Every defined address is readable; 0x0, 0x6, 0x7 fall back to results
  assign readOk = !isWrite && (regSel >= acs_pkg::ADDR_PRIMARY) &&
                  (regSel <= acs_pkg::ADDR_HIGHLIM);

  // The enabling frame must be checked as well as any frame once enabled
  assign needCrc = sys_q.primarySetup[acs_pkg::POS_CRC_W] ||
                   ((regSel == acs_pkg::ADDR_PRIMARY) && payload[acs_pkg::POS_CRC_W]);

  // Mode bits as stored now; an image keeps the modes of its build time
  assign oneWire = sys_q.outputCtl[acs_pkg::POS_SDO];
  assign boost   = sys_q.primarySetup[acs_pkg::POS_RES] & sys_q.primarySetup[acs_pkg::POS_OS_MODE];
  assign crcRdOn = sys_q.primarySetup[acs_pkg::POS_CRC_R];
  // Sixteen-bit results are the top bits of the 18-bit words
  assign resA    = chanAResult[17:2];
  assign resB    = chanBResult[17:2];

  // Readback word: address nibble above the twelve data bits
  always_comb
  begin
    regWord = {1'b0, regSel, 12'h000};
    case (regSel)
      acs_pkg::ADDR_PRIMARY: regWord[11:0] = sys_q.primarySetup;
      acs_pkg::ADDR_OUTCTL:  regWord[11:0] = sys_q.outputCtl;
      // Flags are read live from the converter side, except the sticky fail bit
      acs_pkg::ADDR_FLAGS:
      begin
        regWord[acs_pkg::POS_WFAIL]  = sys_q.writeFail;
        regWord[acs_pkg::POS_SETUP]  = setupFail;
        regWord[acs_pkg::POS_B_HIGH] = limitFlags[3];
        regWord[acs_pkg::POS_B_LOW]  = limitFlags[2];
        regWord[acs_pkg::POS_A_HIGH] = limitFlags[1];
        regWord[acs_pkg::POS_A_LOW]  = limitFlags[0];
      end
      acs_pkg::ADDR_LOWLIM:  regWord[11:0] = sys_q.lowLimit;
      acs_pkg::ADDR_HIGHLIM: regWord[11:0] = sys_q.highLimit;
      default:               regWord[11:0] = 12'h000;
    endcase
  end

  // Checksum over readback word or over both 16-bit results, A first
  assign txCrcIf.data = readOk ? {16'h0000, regWord} : {resA, resB};
  assign txCrcIf.wide = ~readOk;
  assign txCrc        = crcRdOn ? txCrcIf.crc : 8'h00;

  // Held write word is checked against the received checksum byte
  assign rxCrcIf.data = {16'h0000, sys_q.pendWord};
  assign rxCrcIf.wide = 1'b0;

  // ==========================================================================
  // Register write, shared by plain and checked writes
  function automatic acs_pkg::acs_sys_t applyWrite(acs_pkg::acs_sys_t s, logic [15:0] w);
    acs_pkg::acs_sys_t r;
    r = s;
    // Address from the command nibble, data from the low twelve bits
    case (w[acs_pkg::POS_ADDR +: 3])
      acs_pkg::ADDR_PRIMARY: r.primarySetup = w[11:0];
      acs_pkg::ADDR_OUTCTL:  r.outputCtl    = w[11:0];
      acs_pkg::ADDR_LOWLIM:  r.lowLimit     = w[11:0];
      acs_pkg::ADDR_HIGHLIM: r.highLimit    = w[11:0];
      // Read-only flags and undefined addresses change nothing
      default:               r = s;
    endcase
    return r;
  endfunction

  // ==========================================================================
  // System domain
  always_comb
  begin
    sys_d   = sys_q;
    setFail = 1'b0;
    clrFail = 1'b0;

    // Toggles cross through three flops; only stages two and three are compared
    sys_d.wordSync = {sys_q.wordSync[1:0], hld_q.wordTgl};
    sys_d.crcSync  = {sys_q.crcSync[1:0], hld_q.crcTgl};

    // A whole command word has crossed over
    if (wordEvt)
    begin
      sys_d.wrState = acs_pkg::WR_IDLE;
      // Writes needing a checksum wait for it; the rest land at once
      if (isWrite)
      begin
        if (needCrc)
        begin
          // Wait for the checksum byte of this same frame
          sys_d.wrState  = acs_pkg::WR_WAIT_CRC;
          sys_d.pendWord = hld_q.frameWord;
        end
        else
          sys_d = applyWrite(sys_d, hld_q.frameWord);
      end

      // Image for the next access; the host collects it with a further frame
      if (readOk)
      begin
        sys_d.txPrim  = {regWord, txCrc, 20'h00000};
        sys_d.txSec   = 18'h00000;
        sys_d.txSecOn = 1'b0;
        clrFail       = (regSel == acs_pkg::ADDR_FLAGS);
      end
      else
      begin
        // Conversion results; checksum always on the primary line
        case ({oneWire, boost})
          2'b00:   sys_d.txPrim = {resA, txCrc, 20'h00000};
          2'b01:   sys_d.txPrim = {chanAResult, txCrc, 18'h00000};
          2'b10:   sys_d.txPrim = {resA, resB, txCrc, 4'h0};
          2'b11:   sys_d.txPrim = {chanAResult, chanBResult, txCrc};
          default: sys_d.txPrim = '0;
        endcase
        // One-wire mode keeps the second pin low; the enable alone is not enough
        if (oneWire)
          sys_d.txSec = 18'h00000;
        else if (boost)
          sys_d.txSec = chanBResult;
        else
          sys_d.txSec = {resB, 2'b00};
        sys_d.txSecOn = ~oneWire;
      end
    end

    // Checked write: only a matching checksum lets it through
    if (crcEvt && (sys_q.wrState == acs_pkg::WR_WAIT_CRC) && !wordEvt)
    begin
      sys_d.wrState = acs_pkg::WR_IDLE;
      // Both sides are stable here: the byte is only read after its toggle crossed
      if (rxCrcIf.crc == hld_q.crcByte)
        sys_d = applyWrite(sys_d, sys_q.pendWord);
      else
        setFail = 1'b1;
    end

    // A new failure wins over a clear by reading the flags
    sys_d.writeFail = setFail | (sys_q.writeFail & ~clrFail);
  end

  // System flops; reset loads the register defaults
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      sys_q              <= '0;
      sys_q.primarySetup <= acs_pkg::RST_PRIMARY;
      sys_q.outputCtl    <= acs_pkg::RST_OUTCTL;
      sys_q.lowLimit     <= acs_pkg::RST_LOWLIM;
      sys_q.highLimit    <= acs_pkg::RST_HIGHLIM;
      sys_q.wrState      <= acs_pkg::WR_IDLE;
    end
    else
      sys_q <= sys_d;
  end

  // ==========================================================================
  // Outputs, all straight from flops
  assign primarySerialOutput        = frm_q.primOut;
  assign primarySerialOutputEn      = frm_q.primEn;
  assign secondaryOutputOrFlagPin   = frm_q.secOut;
  assign secondaryOutputOrFlagPinEn = frm_q.secEn;

  // Register contents and the sticky flag
  assign primarySetup               = sys_q.primarySetup;
  assign outputCtl                  = sys_q.outputCtl;
  assign lowLimit                   = sys_q.lowLimit;
  assign highLimit                  = sys_q.highLimit;
  assign writeCheckFailureFlag      = sys_q.writeFail;

endmodule

/* File: acs_spi_regs_properties.sv */
module acs_spi_regs_props (
  // Clocks and resets
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic        sclk,
  input wire logic        csN,
  // Serial pins
  input wire logic        primarySerialOutput,
  input wire logic        primarySerialOutputEn,
  input wire logic        secondaryOutputOrFlagPin,
  input wire logic        secondaryOutputOrFlagPinEn,
  // Register outputs
  input wire logic [11:0] primarySetup,
  input wire logic [11:0] outputCtl,
  input wire logic [11:0] lowLimit,
  input wire logic [11:0] highLimit,
  input wire logic        writeCheckFailureFlag
);
  timeunit 1ns;
  timeprecision 100ps;

  // ====================
  // Clocks spent deselected; saturates so a long pause never wraps
  logic [3:0] idleCnt_q;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      idleCnt_q <= 4'h0;
    else if (!csN)
      idleCnt_q <= 4'h0;
    else if (idleCnt_q != 4'hf)
      idleCnt_q <= idleCnt_q + 4'h1;
  end

  // ====================
  // Pins while deselected or in a frame
  a_prim_idle_low: assert property (@(posedge clock) disable iff (!nrst)
    csN |-> !primarySerialOutput && !primarySerialOutputEn) else $error("primary pin active while deselected");
  a_sec_idle_low: assert property (@(posedge clock) disable iff (!nrst)
    csN |-> !secondaryOutputOrFlagPin && !secondaryOutputOrFlagPinEn) else $error("second pin active while idle");
  a_sec_quiet_off: assert property (@(posedge clock) disable iff (!nrst)
    !secondaryOutputOrFlagPinEn |-> !secondaryOutputOrFlagPin) else $error("second pin toggles while off");
  a_en_after_edge: assert property (@(negedge sclk) disable iff (!nrst)
    !csN |-> primarySerialOutputEn) else $error("primary enable missing after a link edge");
  a_en_holds_frame: assert property (@(posedge clock) disable iff (!nrst)
    primarySerialOutputEn && !csN |=> primarySerialOutputEn || csN) else $error("primary enable dropped in frame");

  // ====================
  // Registers change only at reset values or right after a frame
  a_reset_defaults: assert property (@(posedge clock) disable iff (!nrst)
    $rose(nrst) |-> primarySetup == 12'h000 && outputCtl == 12'h000 && lowLimit == 12'h000
      && highLimit == 12'hfff && !writeCheckFailureFlag) else $error("register defaults wrong");
  a_cfg_near_frame: assert property (@(posedge clock) disable iff (!nrst)
    !$stable({primarySetup, outputCtl}) |-> idleCnt_q <= 4'h8) else $error("setup changed with no frame");
  a_lim_near_frame: assert property (@(posedge clock) disable iff (!nrst)
    !$stable({lowLimit, highLimit}) |-> idleCnt_q <= 4'h8) else $error("limit changed with no frame");
  a_flag_near_frame: assert property (@(posedge clock) disable iff (!nrst)
    $changed(writeCheckFailureFlag) |-> idleCnt_q <= 4'h8) else $error("failure flag moved with no frame");
endmodule

bind acs_spi_regs acs_spi_regs_props i_acs_spi_regs_props (
  .clock(clock), .nrst(nrst), .sclk(sclk), .csN(csN),
  .primarySerialOutput(primarySerialOutput), .primarySerialOutputEn(primarySerialOutputEn),
  .secondaryOutputOrFlagPin(secondaryOutputOrFlagPin), .secondaryOutputOrFlagPinEn(secondaryOutputOrFlagPinEn),
  .primarySetup(primarySetup), .outputCtl(outputCtl), .lowLimit(lowLimit), .highLimit(highLimit),
  .writeCheckFailureFlag(writeCheckFailureFlag)
);

/* File: acs_spi_regs_tb_top.sv */
module acs_spi_regs_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  // ====================
  // Device pins and bench state
  logic        clock, nrst, sclk, csN, serialIn;
  logic        primOut, primEn, secOut, secEn, setupFail, wFail;
  logic [17:0] chanA, chanB;
  logic [3:0]  limitFlags;
  logic [11:0] primarySetup, outputCtl, lowLimit, highLimit, d;
  logic [11:0] m [0:7];
  logic [43:0] rxP, rxS;
  logic [31:0] seed;
  logic [2:0]  a;
  logic        one, bst, on;
  int          k, miscompares, checked;

  acs_spi_regs i_acs_spi_regs (
    .clock(clock), .nrst(nrst), .sclk(sclk), .csN(csN), .serialIn(serialIn),
    .primarySerialOutput(primOut), .primarySerialOutputEn(primEn),
    .secondaryOutputOrFlagPin(secOut), .secondaryOutputOrFlagPinEn(secEn),
    .chanAResult(chanA), .chanBResult(chanB), .setupFail(setupFail), .limitFlags(limitFlags),
    .primarySetup(primarySetup), .outputCtl(outputCtl), .lowLimit(lowLimit), .highLimit(highLimit),
    .writeCheckFailureFlag(wFail)
  );
  acs_host_model i_acs_host_model (
    .clock(clock), .sclk(sclk), .csN(csN), .serialIn(serialIn),
    .primarySerialOutput(primOut), .secondaryOutputOrFlagPin(secOut)
  );

  // 50 MHz system clock
  initial clock = 1'b0;
  always #10 clock = ~clock;

  // ====================
  // Expectations
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Zero-seeded remainder, top byte inverted first
  function automatic logic [7:0] crc(input logic [31:0] w, input int n);
    logic [7:0] c;
    c = 8'h00;
    w[n - 1 -: 8] = ~w[n - 1 -: 8];
    for (int i = n - 1; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction

  function automatic logic [43:0] img(input logic [15:0] w, input logic ron);
    return {w, ron ? crc(32'(w), 16) : 8'h00, 20'h0};
  endfunction

  // Conversion image for the current mode
  function automatic logic [43:0] conv();
    logic [7:0] c;
    c = on ? crc({chanA[17:2], chanB[17:2]}, 32) : 8'h00;
    if (one)
      return bst ? {chanA, chanB, c} : {chanA[17:2], chanB[17:2], c, 4'h0};
    return bst ? {chanA, c, 18'h0} : {chanA[17:2], c, 20'h0};
  endfunction

  // ====================
  // Compare and transfer tasks
  task automatic cmp_reg(input string what, input logic [11:0] exp, input logic [11:0] got);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Only the bits actually clocked are compared
  task automatic cmp_ser(input string what, input logic [43:0] exp, input logic [43:0] got, input int n);
    logic [43:0] mask;
    mask = ~({44{1'b1}} >> n);
    checked++;
    if ((got & mask) !== (exp & mask))
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp & mask, got);
    end
  endtask

  // Write; mode 0 plain, 1 good checksum, 2 corrupted checksum
  task automatic wr(input logic [2:0] ad, input logic [11:0] dt, input int mode);
    logic [15:0] w;
    w = {1'b1, ad, dt};
    i_acs_host_model.frame({w, crc(32'(w), 16) ^ ((mode == 2) ? 8'h01 : 8'h00)}, (mode == 0) ? 16 : 24, rxP, rxS);
  endtask

  // Request, then a second frame that shifts the answer out
  task automatic rd(input logic [2:0] ad, input int n);
    i_acs_host_model.frame({1'b0, ad, 20'h0}, 16, rxP, rxS);
    i_acs_host_model.frame(24'h0, n, rxP, rxS);
  endtask

  task automatic chk_all();
    cmp_reg("primarySetup", m[1], primarySetup);
    cmp_reg("outputCtl", m[2], outputCtl);
    cmp_reg("lowLimit", m[4], lowLimit);
    cmp_reg("highLimit", m[5], highLimit);
    for (int i = 1; i < 6; i++)
      if (i != 3)
      begin
        rd(3'(i), 24);
        cmp_ser("readback", img({1'b0, 3'(i), m[i]}, m[1][4]), rxP, 24);
      end
  endtask

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Watchdog against a hung run
  initial
  begin
    repeat (100000) @(posedge clock);
    miscompares++;
    tally_and_finish();
  end

  // ====================
  // Main sequence
  initial
  begin
    seed = 32'h814af9dc;
    nrst = 1'b0;
    {chanA, chanB, setupFail, limitFlags} = '0;
    m = '{default: 12'h000};
    m[5] = 12'hfff;
    miscompares = 0;
    checked = 0;
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    chk_all();
    // Random writes over the whole map, checksum enables kept off
    for (k = 0; k < 16; k++)
    begin
      a = 3'(k);
      d = 12'(rnd()) & 12'hfcf;
      @(posedge clock);
      chanA <= 18'(rnd());
      chanB <= 18'(rnd());
      wr(a, d, 0);
      if (a inside {3'h1, 3'h2, 3'h4, 3'h5})
        m[a] = d;
    end
    chk_all();
    // Every output mode, read checksum off and on, via undefined reads
    for (k = 0; k < 8; k++)
    begin
      {on, bst, one} = 3'(k);
      m[1] = (bst ? 12'h204 : 12'h000) | (on ? 12'h010 : 12'h000);
      m[2] = one ? 12'h100 : 12'h000;
      wr(3'h1, m[1], 0);
      wr(3'h2, m[2], 0);
      @(posedge clock);
      chanA <= (k == 4) ? 18'h2aaa8 : 18'(rnd());
      chanB <= (k == 4) ? 18'h15554 : 18'(rnd());
      rd((k % 3 == 0) ? 3'h0 : 3'(k % 3 + 5), 44);
      cmp_ser("primary", conv(), rxP, 44);
      cmp_ser("secondary", one ? 44'h0 : (bst ? {chanB, 26'h0} : {chanB[17:2], 28'h0}), rxS, 44);
      if (k == 4)
        cmp_ser("known checksum", {16'haaaa, 8'h9c, 20'h0}, rxP, 24);
    end
    chk_all();
    m[1] = 12'h000;
    wr(3'h1, m[1], 0);
    // Enabling write checksums: short frame, bad, then good
    wr(3'h1, 12'h020, 0);
    cmp_reg("failFlag", 12'h000, {11'h0, wFail});
    wr(3'h1, 12'h020, 2);
    cmp_reg("failFlag", 12'h001, {11'h0, wFail});
    chk_all();
    wr(3'h1, 12'h020, 1);
    m[1] = 12'h020;
    wr(3'h4, 12'(rnd()), 0);
    wr(3'h1, 12'h000, 2);
    chk_all();
    // Flags readback with a checked write to the read-only place
    @(posedge clock);
    setupFail <= 1'(rnd());
    limitFlags <= 4'(rnd());
    wr(3'h3, 12'hfff, 1);
    rd(3'h3, 16);
    cmp_ser("flags", img({4'h3, 2'b0, 1'b1, setupFail, 2'b0, limitFlags[3:2], 2'b0, limitFlags[1:0]}, 1'b0), rxP, 16);
    cmp_reg("failFlag", 12'h000, {11'h0, wFail});
    m[4] = 12'(rnd());
    wr(3'h4, m[4], 1);
    m[1] = 12'h000;
    wr(3'h1, m[1], 1);
    chk_all();
    tally_and_finish();
  end
endmodule
